// ==== verification/fawp_cpu_model.sv ====
// fawp_cpu_model: cpu fetch and data access paths facing the block
`timescale 1ns/1ps
module fawp_cpu_model (
   input wire logic mclk,
   output fawp_pkg::fawp_fetch_t fetch,
   output fawp_pkg::fawp_req_t accReq
);
   // idle: primary flash fetch, no request
   initial begin
      fetch = '0;
      accReq = '0;
   end
   ////////////////////
   // valid one cycle, then qualifiers scrambled so stale ones fail
   task automatic issue(input fawp_pkg::fawp_fetch_t f, input fawp_pkg::fawp_req_t r);
      @(posedge mclk);
      fetch <= f;
      accReq <= r;
      @(posedge mclk);
      accReq <= {1'b0, ~r[$bits(r)-2:0]};
   endtask : issue
   // new instruction source
   task automatic move(input fawp_pkg::fawp_fetch_t f);
      @(posedge mclk);
      fetch <= f;
   endtask : move
endmodule : fawp_cpu_model

// ==== verification/fawp_top_sva.sv ====
// fawp_top_sva: port assertions
`timescale 1ns/1ps
module fawp_top_sva (
   input wire logic mclk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire fawp_pkg::fawp_fetch_t fetch,
   input wire fawp_pkg::fawp_req_t accReq,
   input wire logic accGrant,
   input wire logic accDummy,
   input wire logic testIfEnable,
   input wire logic accessLockActive
);
   // one clock domain
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   ////////////////////
   chk_load_locked: assert property ($fell(rst) |-> (accessLockActive && !testIfEnable) [*6])
      else $error("protection dropped during load");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_setup_wait: assert property (psel && !penable |-> !pready)
      else $error("answer in setup cycle");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   // decisions land one cycle after the request
   chk_ram_dummy: assert property (accReq.valid && accReq.kind == fawp_pkg::AK_READ
      && accReq.region == fawp_pkg::RG_PRIMARY_FLASH && fetch.region == fawp_pkg::RG_INTERNAL_RAM_SMALL
      && accessLockActive |=> !accGrant && accDummy)
      else $error("ram read of locked flash not dummied");
   chk_ext_free: assert property (accReq.valid && accReq.region == fawp_pkg::RG_EXT_FLASH
      && accReq.kind inside {fawp_pkg::AK_READ, fawp_pkg::AK_JUMP}
      && !accReq.fromPec && !accReq.fromTest |=> accGrant)
      else $error("extension flash access denied");
   chk_jump_free: assert property (accReq.valid && accReq.kind == fawp_pkg::AK_JUMP
      && accReq.region == fawp_pkg::RG_PRIMARY_FLASH
      && !accReq.fromPec && !accReq.fromTest |=> accGrant)
      else $error("jump into primary flash denied");
   chk_pec_block: assert property (accReq.valid && accReq.fromPec && accessLockActive
      && accReq.region == fawp_pkg::RG_PRIMARY_FLASH |=> !accGrant)
      else $error("transfer channel reached locked flash");
   chk_test_off: assert property (accReq.valid && accReq.fromTest && !testIfEnable
      |=> !accGrant)
      else $error("test access granted while disabled");
endmodule : fawp_top_sva

bind fawp_top fawp_top_sva fawp_top_sva_inst (.mclk(mclk), .rst(rst), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr), .fetch(fetch), .accReq(accReq),
   .accGrant(accGrant), .accDummy(accDummy), .testIfEnable(testIfEnable),
   .accessLockActive(accessLockActive));

// ==== verification/flash_access_write_protection_tb.sv ====
// flash_access_write_protection_tb: self-checking bench
`timescale 1ns/1ps
`include "fawp_consts.svh"
module flash_access_write_protection_tb;
   localparam fawp_pkg::fawp_kind_t RD = fawp_pkg::AK_READ;
   localparam fawp_pkg::fawp_kind_t JP = fawp_pkg::AK_JUMP;
   localparam fawp_pkg::fawp_kind_t PG = fawp_pkg::AK_PROGRAM;
   localparam fawp_pkg::fawp_region_t PFL = fawp_pkg::RG_PRIMARY_FLASH;
   localparam fawp_pkg::fawp_region_t XFL = fawp_pkg::RG_EXT_FLASH;
   localparam fawp_pkg::fawp_fetch_t PF0 = '{PFL, 2'h0};
   localparam fawp_pkg::fawp_fetch_t PF1 = '{PFL, 2'h1};
   localparam fawp_pkg::fawp_fetch_t RAM = '{fawp_pkg::RG_INTERNAL_RAM_SMALL, 2'h0};
   logic mclk, rst, psel, penable, pwrite, pready, pslverr, accGrant, accDummy;
   logic testIfEnable, accessLockActive;
   logic [31:0] paddr, pwdata, prdata;
   fawp_pkg::fawp_fetch_t fetch;
   fawp_pkg::fawp_req_t accReq;
   fawp_pkg::fawp_region_t fr;
   integer n_errors = 0;
   integer n_checks = 0;
   integer seed = 32'h912d;

   fawp_top fawp_top_inst (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .fetch(fetch), .accReq(accReq), .accGrant(accGrant),
      .accDummy(accDummy), .testIfEnable(testIfEnable), .accessLockActive(accessLockActive));
   fawp_cpu_model fawp_cpu_model_inst (.mclk(mclk), .fetch(fetch), .accReq(accReq));

   // 40 MHz clock
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   ////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic finish_test;
      $display("checks=%0d mismatches=%0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : finish_test

   // locked flash data readable only from primary fetch
   function automatic logic expRead(input fawp_pkg::fawp_region_t f);
      return f == PFL;
   endfunction : expRead

   // request held until pready; data and error taken then
   task automatic apb(input logic w, input logic [23:0] idx, input logic [15:0] d,
      input logic [31:0] expD, input logic expE);
      integer n;
      logic [31:0] got;
      logic e;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {6'h0, idx, 2'h0};
      pwdata <= {16'h0, d};
      @(posedge mclk);
      penable <= 1'b1;
      #1;
      while (pready !== 1'b1 && n < 40) begin
         @(posedge mclk);
         #1;
         n++;
      end
      if (n == 40) begin
         n_errors++;
         finish_test;
      end
      got = prdata;
      e = pslverr;
      @(posedge mclk);
      psel <= 1'b0;
      penable <= 1'b0;
      if (!w && !expE) chk(got, expD);
      chk(e, expE);
   endtask : apb

   // one request; grant read the cycle after, once it is withdrawn
   task automatic acc(input fawp_pkg::fawp_fetch_t f, input fawp_pkg::fawp_kind_t k,
      input fawp_pkg::fawp_region_t r, input logic [3:0] s, input logic [1:0] src,
      input logic expG);
      fawp_cpu_model_inst.issue(f, '{1'b1, k, r, 2'h0, s, src[1], src[0]});
      #1;
      chk(accGrant, expG);
   endtask : acc

   // reset, then wait out the fuse load
   task automatic reboot;
      @(posedge mclk);
      rst <= 1'b1;
      repeat (4) @(posedge mclk);
      chk(accessLockActive, 1'b1);
      chk(testIfEnable, 1'b0);
      rst <= 1'b0;
      repeat (20) @(posedge mclk);
   endtask : reboot

   // main sequence
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      reboot;
      apb(0, `FAWP_IDX_STAT, 16'h0, 32'h12, 0);
      apb(0, `FAWP_IDX_REN, 16'h0, 32'hffff, 0);
      apb(0, 24'h0edfc4, 16'h0, 32'h0, 1);
      apb(1, `FAWP_IDX_STAT, 16'h0, 32'h0, 1);
      apb(1, `FAWP_IDX_DIS, 16'hfffe, 32'h0, 1);
      apb(1, `FAWP_IDX_IWL, 16'hfffe, 32'h0, 0);
      apb(1, `FAWP_IDX_AP0, 16'h0000, 32'h0, 0);
      apb(0, `FAWP_IDX_AP0, 16'h0, 32'h0, 0);
      reboot;
      chk(accessLockActive, 1'b1);
      chk(testIfEnable, 1'b0);
      $display("test 1 done");
      acc(RAM, RD, PFL, 4'h0, 2'h0, 0);
      chk(accDummy, 1'b1);
      acc(PF0, RD, PFL, 4'h0, 2'h0, 1);
      acc(RAM, JP, PFL, 4'h0, 2'h0, 1);
      acc(RAM, RD, XFL, 4'h0, 2'h0, 1);
      acc(PF0, RD, PFL, 4'h0, 2'h2, 0);
      acc(PF0, RD, XFL, 4'h0, 2'h1, 0);
      acc(PF1, PG, PFL, 4'h0, 2'h0, 0);
      acc('{XFL, 2'h2}, PG, PFL, 4'h1, 2'h0, 1);
      for (int i = 0; i < 24; i++) begin
         fr = fawp_pkg::fawp_region_t'($unsigned($random(seed)) % 5);
         acc('{fr, 2'h0}, RD, PFL, 4'h0, 2'h0, expRead(fr));
      end
      $display("test 2 done");
      fawp_cpu_model_inst.move(RAM);
      apb(1, `FAWP_IDX_AP0, 16'hfffd, 32'h0, 1);
      fawp_cpu_model_inst.move(PF0);
      apb(1, `FAWP_IDX_IWL, 16'hffff, 32'h0, 0);
      acc(PF1, PG, PFL, 4'h0, 2'h0, 1);
      apb(1, `FAWP_IDX_AP0, 16'hfffd, 32'h0, 0);
      chk(accessLockActive, 1'b0);
      apb(0, `FAWP_IDX_AP0, 16'h0, 32'h0, 0);
      apb(1, `FAWP_IDX_DIS, 16'hfffe, 32'h0, 1);
      reboot;
      chk(accessLockActive, 1'b1);
      $display("test 3 done");
      apb(1, `FAWP_IDX_DIS, 16'hfffd, 32'h0, 1);
      apb(1, `FAWP_IDX_REN, 16'hfffe, 32'h0, 1);
      apb(1, `FAWP_IDX_DIS, 16'hfffe, 32'h0, 0);
      reboot;
      chk(accessLockActive, 1'b0);
      acc(RAM, RD, PFL, 4'h0, 2'h0, 1);
      fawp_cpu_model_inst.move(PF0);
      apb(1, `FAWP_IDX_REN, 16'hfffe, 32'h0, 0);
      reboot;
      chk(accessLockActive, 1'b1);
      apb(1, `FAWP_IDX_DIS, 16'hfffc, 32'h0, 0);
      reboot;
      chk(accessLockActive, 1'b0);
      $display("test 4 done");
      finish_test;
   end
endmodule : flash_access_write_protection_tb

// ==== verilog/fawp_access_check.sv ====
// fawp_access_check: grant decision for one memory request
`timescale 1ns/1ps
`include "fawp_consts.svh"
module fawp_access_check (
   input wire fawp_pkg::fawp_req_t req,
   input wire fawp_pkg::fawp_fetch_t fetch,
   input wire fawp_pkg::fawp_prot_t prot,
   output logic grant,
   output logic dummy
);

   // sector open test; out-of-range sectors count as locked
   function automatic logic sectorOpen(fawp_pkg::fawp_prot_t p, logic [1:0] bank,
                                       logic [3:0] sec);
      logic r;
      r = 1'b0;
      case (bank)
         2'h0: r = (sec < `FAWP_SEC_B0) ? p.bank0Open[sec] : 1'b0;
         2'h1: r = (sec < `FAWP_SEC_B1) ? p.bank1Open[sec[0]] : 1'b0;
         2'h2: r = (sec < `FAWP_SEC_B2) ? p.bank2Open[sec[1:0]] : 1'b0;
         default: r = (sec < `FAWP_SEC_B3) ? p.bank3Open[sec[0]] : 1'b0;
      endcase
      return r;
   endfunction : sectorOpen

   logic fetchPrimary;
   logic fetchFlash;
   logic dataLocked;
   logic open;

   assign fetchPrimary = (fetch.region == fawp_pkg::RG_PRIMARY_FLASH);
   assign fetchFlash = fetchPrimary || (fetch.region == fawp_pkg::RG_EXT_FLASH);
   assign open = sectorOpen(prot, req.bank, req.sector);
   // while locked, foreign data blocked and transfer channel blocked whatever the fetch
   assign dataLocked = prot.accLock && (!fetchPrimary || req.fromPec);

   // decision per target region and kind
   always_comb begin
      grant = 1'b0;
      dummy = 1'b0;
      if (req.valid) begin
         if (req.fromTest) begin
            // test interface only while debug lock erased
            grant = prot.debugEn;
         end else begin
            case (req.region)
               fawp_pkg::RG_PRIMARY_FLASH: begin
                  case (req.kind)
                     // jumps into primary flash always allowed
                     fawp_pkg::AK_JUMP: grant = 1'b1;
                     // sector lock; other bank may update
                     fawp_pkg::AK_PROGRAM: grant = open && (!prot.accLock || fetchPrimary ||
                        (fetchFlash && fetch.bank != req.bank));
                     default: begin
                        // blocked write drops, blocked read gives dummy data
                        grant = !dataLocked;
                        dummy = dataLocked && (req.kind == fawp_pkg::AK_READ);
                     end
                  endcase
               end
               fawp_pkg::RG_EXT_FLASH: begin
                  grant = (req.kind == fawp_pkg::AK_PROGRAM) ? open : 1'b1;
               end
               default: grant = 1'b1;
            endcase
         end
      end
   end

endmodule : fawp_access_check

// ==== verilog/fawp_consts.svh ====
// fawp_consts.svh: constants of the protection block
`ifndef FAWP_CONSTS_SVH
`define FAWP_CONSTS_SVH

// register indices; byte address is four times the index
`define FAWP_IDX_XWL 24'h0edfb0
`define FAWP_IDX_XWH 24'h0edfb2
`define FAWP_IDX_IWL 24'h0edfb4
`define FAWP_IDX_IWH 24'h0edfb6
`define FAWP_IDX_AP0 24'h0edfb8
`define FAWP_IDX_DIS 24'h0edfbc
`define FAWP_IDX_REN 24'h0edfbe
`define FAWP_IDX_STAT 24'h0edfc0

// fuse memory slots
`define FAWP_SLOTS 7
`define FAWP_SLOT_XWL 3'h0
`define FAWP_SLOT_XWH 3'h1
`define FAWP_SLOT_IWL 3'h2
`define FAWP_SLOT_IWH 3'h3
`define FAWP_SLOT_AP0 3'h4
`define FAWP_SLOT_DIS 3'h5
`define FAWP_SLOT_REN 3'h6
`define FAWP_LAST_SLOT 3'h6

// program sequence steps
`define FAWP_STEP_AP0 2'h0
`define FAWP_STEP_DIS 2'h1
`define FAWP_STEP_REN 2'h2
`define FAWP_STEP_TGT 2'h3

// fuse word values and bit positions
`define FAWP_ERASED 16'hffff
`define FAWP_PROGRAMMED 16'h0000
`define FAWP_BIT_ACC 0
`define FAWP_BIT_DBG 1
`define FAWP_ACC_ONLY 16'h0001

// status register bits
`define FAWP_ST_LOCK 0
`define FAWP_ST_DBG 1
`define FAWP_ST_SUSP 2
`define FAWP_ST_TEMP 3
`define FAWP_ST_LOADED 4

// sector counts per bank
`define FAWP_SEC_B0 4'ha
`define FAWP_SEC_B1 4'h2
`define FAWP_SEC_B2 4'h3
`define FAWP_SEC_B3 4'h2

`endif

// ==== verilog/fawp_fuse_mem.sv ====
// fawp_fuse_mem: one-time-programmable fuse words
`timescale 1ns/1ps
`include "fawp_consts.svh"
module fawp_fuse_mem (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [2:0] rdAddr,
   output logic [15:0] rdData,
   input wire logic wrEn,
   input wire logic [2:0] wrAddr,
   input wire logic [15:0] wrData
);

   // delivered erased; reset never touches the cells
   logic [15:0] cells [0:`FAWP_SLOTS-1] = '{default: `FAWP_ERASED};

   // a fuse can only fall from 1 to 0
   always_ff @(posedge mclk) begin
      if (wrEn) begin
         cells[wrAddr] <= cells[wrAddr] & wrData;
      end
   end

   // registered read port
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rdData <= `FAWP_PROGRAMMED;
      end else begin
         rdData <= cells[rdAddr];
      end
   end

endmodule : fawp_fuse_mem

// ==== verilog/fawp_pkg.sv ====
// fawp_pkg: types of the protection block
package fawp_pkg;

   typedef enum logic [2:0] {
      RG_PRIMARY_FLASH,
      RG_EXT_FLASH,
      RG_INTERNAL_RAM_SMALL,
      RG_EXTENSION_RAM,
      RG_EXTMEM
   } fawp_region_t;

   typedef enum logic [1:0] {
      AK_READ,
      AK_WRITE,
      AK_JUMP,
      AK_PROGRAM
   } fawp_kind_t;

   typedef struct packed {
      logic valid;
      fawp_kind_t kind;
      fawp_region_t region;
      logic [1:0] bank;
      logic [3:0] sector;
      logic fromPec;
      logic fromTest;
   } fawp_req_t;

   typedef struct packed {
      fawp_region_t region;
      logic [1:0] bank;
   } fawp_fetch_t;

   typedef struct packed {
      logic accLock;
      logic debugEn;
      logic [9:0] bank0Open;
      logic [1:0] bank1Open;
      logic [2:0] bank2Open;
      logic [1:0] bank3Open;
   } fawp_prot_t;

endpackage : fawp_pkg

// ==== verilog/fawp_top.sv ====
// fawp_top: flash access and write protection with APB register slave
//
// Functional notes
// - access lock at 0 blocks primary flash data unless fetched from primary flash
// - debug lock 1 allows test bypass, 0 disables test interface
// - disable fuse x at 0 with re-enable x at 1 suspends access lock
// - disable fuse 0 needs debug and access locks programmed
// - disable fuse x needs re-enable fuse x-1 programmed
// - re-enable x programmed, disable x+1 erased restores access lock
// - re-enable fuse x needs disable fuse x programmed
// - sixteen fuse pairs give sixteen lock rounds
// - locked flash: RAM code writes dropped, reads give dummy
// - transfer channel access to protected flash is forbidden; code blocks only its reads and writes, not jumps or programs
// - extension flash has no access protection
// - non-primary fetch while locked: no primary flash data reads or register writes
// - sector write lock programmed at 0 write-protects that sector
// - writing 1 to sector lock lifts it via volatile copy
// - writing 1 lifts access lock only when run from flash
// - after a lift only reset restores or allows programming
// - lift touches only volatile copy; reads show fuses
// - other-bank code may update locked flash without a lift
// - reset forces protections, then fuses copy into seven volatile words
// - fuses are one time programmable, only 1 to 0
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`include "fawp_consts.svh"
module fawp_top (
   input wire logic mclk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire fawp_pkg::fawp_fetch_t fetch,
   input wire fawp_pkg::fawp_req_t accReq,
   output logic accGrant,
   output logic accDummy,
   output logic testIfEnable,
   output logic accessLockActive
);

   ////////////////////////////////////////////////////////////////////////////
   // types and state

   typedef enum logic [3:0] {
      ST_LOAD_RD,
      ST_LOAD_CAP,
      ST_IDLE,
      ST_RD_CAP,
      ST_PG_RD,
      ST_PG_CAP,
      ST_PG_WR,
      ST_DONE
   } fawp_state_t;

   fawp_state_t state_reg;
   fawp_state_t state_next;
   logic [2:0] loadSlot_reg;
   logic [1:0] step_reg;
   logic [2:0] slot_reg;
   logic [15:0] wdata_reg;
   logic [15:0] vol_reg [0:`FAWP_SLOTS-1];
   logic [15:0] tmp_reg [0:3];
   logic tempDone_reg;
   logic [31:0] prdata_reg;
   logic pslverr_reg;
   logic accGrant_reg;
   logic accDummy_reg;

   logic [2:0] memRdAddr;
   logic [15:0] memRdData;
   logic memWrEn;
   logic setup;
   logic decHit;
   logic statHit;
   logic [2:0] decSlot;
   logic suspended;
   logic accLockEff;
   logic regWriteDenied;
   logic fetchFlash;
   logic [15:0] newZeros;
   logic [15:0] allowMask;
   logic [15:0] liftMask;
   logic refuse;
   logic [15:0] statusWord;
   fawp_pkg::fawp_prot_t prot;
   logic chkGrant;
   logic chkDummy;

   ////////////////////////////////////////////////////////////////////////////
   // helper functions

   // address to fuse slot; aligned low-range words only
   function automatic logic [3:0] decode(logic [31:0] a);
      logic [3:0] r;
      r = 4'h0;
      if (a[1:0] == 2'h0 && a[31:26] == 6'h00) begin
         case (a[25:2])
            `FAWP_IDX_XWL: r = {1'b1, `FAWP_SLOT_XWL};
            `FAWP_IDX_XWH: r = {1'b1, `FAWP_SLOT_XWH};
            `FAWP_IDX_IWL: r = {1'b1, `FAWP_SLOT_IWL};
            `FAWP_IDX_IWH: r = {1'b1, `FAWP_SLOT_IWH};
            `FAWP_IDX_AP0: r = {1'b1, `FAWP_SLOT_AP0};
            `FAWP_IDX_DIS: r = {1'b1, `FAWP_SLOT_DIS};
            `FAWP_IDX_REN: r = {1'b1, `FAWP_SLOT_REN};
            default: r = 4'h0;
         endcase
      end
      return r;
   endfunction : decode

   // slot read at each step of a set protection operation
   function automatic logic [2:0] stepSlot(logic [1:0] step, logic [2:0] target);
      logic [2:0] r;
      case (step)
         `FAWP_STEP_AP0: r = `FAWP_SLOT_AP0;
         `FAWP_STEP_DIS: r = `FAWP_SLOT_DIS;
         `FAWP_STEP_REN: r = `FAWP_SLOT_REN;
         default: r = target;
      endcase
      return r;
   endfunction : stepSlot

   // bits of the target word that the fuse chain lets fall to 0
   function automatic logic [15:0] chainAllow(logic [2:0] slot, logic [15:0] ap0,
                                              logic [15:0] dis, logic [15:0] ren);
      logic [15:0] m;
      m = `FAWP_ERASED;
      case (slot)
         `FAWP_SLOT_DIS: begin
            // first disable fuse needs debug and access lock programmed
            m[0] = (ap0[`FAWP_BIT_DBG] == 1'b0) && (ap0[`FAWP_BIT_ACC] == 1'b0);
            // each later disable fuse follows the previous re-enable
            m[15:1] = ~ren[14:0];
         end
         // re-enable fuse follows its own disable fuse
         `FAWP_SLOT_REN: m = ~dis;
         default: m = `FAWP_ERASED;
      endcase
      return m;
   endfunction : chainAllow

   ////////////////////////////////////////////////////////////////////////////
   // effective protection from the volatile copies

   // lock suspended by any open pair
   assign suspended = |(~vol_reg[`FAWP_SLOT_DIS] & vol_reg[`FAWP_SLOT_REN]);
   // lock in force while its copy reads 0 and no pair suspends it
   assign accLockEff = !vol_reg[`FAWP_SLOT_AP0][`FAWP_BIT_ACC] && !suspended;

   // copies reset to 0, so all locks hold until loaded
   assign prot.accLock = accLockEff;
   assign prot.debugEn = vol_reg[`FAWP_SLOT_AP0][`FAWP_BIT_DBG];
   // sector open only while its volatile copy is 1
   assign prot.bank0Open = vol_reg[`FAWP_SLOT_IWL][9:0];
   assign prot.bank1Open = vol_reg[`FAWP_SLOT_IWH][1:0];
   assign prot.bank2Open = vol_reg[`FAWP_SLOT_XWL][2:0];
   assign prot.bank3Open = vol_reg[`FAWP_SLOT_XWH][1:0];

   fawp_access_check u_check (
      .req(accReq),
      .fetch(fetch),
      .prot(prot),
      .grant(chkGrant),
      .dummy(chkDummy)
   );

   fawp_fuse_mem u_mem (
      .mclk(mclk),
      .rst(rst),
      .rdAddr(memRdAddr),
      .rdData(memRdData),
      .wrEn(memWrEn),
      .wrAddr(slot_reg),
      .wrData(wdata_reg)
   );

   ////////////////////////////////////////////////////////////////////////////
   // bus decode and set protection evaluation

   assign setup = psel && !penable;
   assign {decHit, decSlot} = decode(paddr);
   assign statHit = (paddr[1:0] == 2'h0) && (paddr[31:26] == 6'h00) &&
                    (paddr[25:2] == `FAWP_IDX_STAT);
   assign fetchFlash = (fetch.region == fawp_pkg::RG_PRIMARY_FLASH) ||
                       (fetch.region == fawp_pkg::RG_EXT_FLASH);

   // flash register writes need a primary flash fetch while locked
   assign regWriteDenied = accLockEff && (fetch.region != fawp_pkg::RG_PRIMARY_FLASH);

   // fuses the write would newly program
   assign newZeros = tmp_reg[`FAWP_STEP_TGT] & ~wdata_reg;
   assign allowMask = chainAllow(slot_reg, tmp_reg[`FAWP_STEP_AP0],
                                 tmp_reg[`FAWP_STEP_DIS], tmp_reg[`FAWP_STEP_REN]);

   // bits a 1 may lift; chain fuses have no volatile meaning
   always_comb begin
      liftMask = `FAWP_PROGRAMMED;
      case (slot_reg)
         // access lock lifts only for code running from flash
         `FAWP_SLOT_AP0: liftMask = fetchFlash ? `FAWP_ACC_ONLY : `FAWP_PROGRAMMED;
         `FAWP_SLOT_DIS: liftMask = `FAWP_PROGRAMMED;
         `FAWP_SLOT_REN: liftMask = `FAWP_PROGRAMMED;
         // sector locks lift by writing 1
         default: liftMask = `FAWP_ERASED;
      endcase
   end

   // no programming after a temporary unprotection until reset
   assign refuse = (|(newZeros & ~allowMask)) || (tempDone_reg && (|newZeros)) ||
                   regWriteDenied;
   // the memory ands the new zeros into the cells
   assign memWrEn = (state_reg == ST_PG_WR) && !refuse && (|newZeros);

   // fuse memory read address
   always_comb begin
      case (state_reg)
         ST_LOAD_RD: memRdAddr = loadSlot_reg;
         ST_IDLE: memRdAddr = decSlot;
         ST_PG_RD: memRdAddr = stepSlot(step_reg, slot_reg);
         default: memRdAddr = `FAWP_SLOT_XWL;
      endcase
   end

   // status word: block state, not fuse contents
   always_comb begin
      statusWord = 16'h0000;
      statusWord[`FAWP_ST_LOCK] = accLockEff;
      statusWord[`FAWP_ST_DBG] = prot.debugEn;
      statusWord[`FAWP_ST_SUSP] = suspended;
      statusWord[`FAWP_ST_TEMP] = tempDone_reg;
      statusWord[`FAWP_ST_LOADED] = (state_reg != ST_LOAD_RD) && (state_reg != ST_LOAD_CAP);
   end

   ////////////////////////////////////////////////////////////////////////////
   // control state machine

   // next state; setup is seen only in ST_IDLE, so a request begun during the load never gets pready
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_LOAD_RD: state_next = ST_LOAD_CAP;
         ST_LOAD_CAP: state_next = (loadSlot_reg == `FAWP_LAST_SLOT) ? ST_IDLE : ST_LOAD_RD;
         ST_IDLE: begin
            if (setup) begin
               if (decHit) begin
                  state_next = pwrite ? ST_PG_RD : ST_RD_CAP;
               end else begin
                  state_next = ST_DONE;
               end
            end
         end
         ST_RD_CAP: state_next = ST_DONE;
         ST_PG_RD: state_next = ST_PG_CAP;
         ST_PG_CAP: state_next = (step_reg == `FAWP_STEP_TGT) ? ST_PG_WR : ST_PG_RD;
         ST_PG_WR: state_next = ST_DONE;
         ST_DONE: state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_LOAD_RD;
      end else begin
         state_reg <= state_next;
      end
   end

   // walk the seven slots once after reset
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         loadSlot_reg <= `FAWP_SLOT_XWL;
      end else if (state_reg == ST_LOAD_CAP && loadSlot_reg != `FAWP_LAST_SLOT) begin
         loadSlot_reg <= loadSlot_reg + 3'h1;
      end
   end

   // program step counter and captured request
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         step_reg <= `FAWP_STEP_AP0;
         slot_reg <= `FAWP_SLOT_XWL;
         wdata_reg <= `FAWP_ERASED;
      end else if (state_reg == ST_IDLE && setup) begin
         step_reg <= `FAWP_STEP_AP0;
         slot_reg <= decSlot;
         wdata_reg <= pwdata[15:0];
      end else if (state_reg == ST_PG_CAP && step_reg != `FAWP_STEP_TGT) begin
         step_reg <= step_reg + 2'h1;
      end
   end

   // fuse words read back for the chain check
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 4; i++) begin
            tmp_reg[i] <= `FAWP_ERASED;
         end
      end else if (state_reg == ST_PG_CAP) begin
         tmp_reg[step_reg] <= memRdData;
      end
   end

   // forced to 0 during reset, then loaded from the fuses
   // a lift sets only the volatile copy; fuse cells keep their 0
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < `FAWP_SLOTS; i++) begin
            vol_reg[i] <= `FAWP_PROGRAMMED;
         end
      end else if (state_reg == ST_LOAD_CAP) begin
         vol_reg[loadSlot_reg] <= memRdData;
      end else if (state_reg == ST_PG_WR && !refuse) begin
         vol_reg[slot_reg] <= vol_reg[slot_reg] | (wdata_reg & liftMask);
      end
   end

   // sticky until reset once any programmed fuse was lifted
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         tempDone_reg <= 1'b0;
      end else if (state_reg == ST_PG_WR && !refuse &&
                   (|(wdata_reg & liftMask & ~tmp_reg[`FAWP_STEP_TGT]))) begin
         tempDone_reg <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus answer

   // fuse register reads show fuse cells, never a lift; status reads show block state
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         prdata_reg <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (setup) begin
                  prdata_reg <= (statHit && !pwrite) ? {16'h0000, statusWord} : 32'h0000_0000;
                  // unmapped addresses and writes to status fail
                  pslverr_reg <= !decHit && !(statHit && !pwrite);
               end
            end
            ST_RD_CAP: prdata_reg <= {16'h0000, memRdData};
            ST_PG_WR: pslverr_reg <= refuse;
            default: pslverr_reg <= pslverr_reg;
         endcase
      end
   end

   assign prdata = prdata_reg;
   assign pready = (state_reg == ST_DONE);
   assign pslverr = (state_reg == ST_DONE) && pslverr_reg;

   ////////////////////////////////////////////////////////////////////////////
   // memory request decision

   // one cycle of latency traded for a clean flop-driven grant
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         accGrant_reg <= 1'b0;
         accDummy_reg <= 1'b0;
      end else begin
         accGrant_reg <= chkGrant;
         accDummy_reg <= chkDummy;
      end
   end

   assign accGrant = accGrant_reg;
   assign accDummy = accDummy_reg;
   // test interface follows the debug lock copy
   assign testIfEnable = prot.debugEn;
   assign accessLockActive = accLockEff;

endmodule : fawp_top
